// ---- hw/cfgs_cfg.svh ----
// Contract
// - After power-up or hardware reset the active bus settings come from the nonvolatile register, and from the volatile one once it is loaded.
// - A software reset leaves the settings source as it is; only power-on or hardware reset returns it to nonvolatile.
// - Programming or erasing the nonvolatile register leaves an already loaded volatile register untouched.
// - If the volatile register was never loaded, programming the nonvolatile register copies the new value into it.
// - Programming or erasing the nonvolatile register changes active behaviour only after the next hardware reset; power-on restores the factory value.
// - Loading the volatile register changes active behaviour at once.
// - With the freeze bit at 0 both registers refuse changes; at 1 both are open.
// - Programming the nonvolatile freeze bit while both are 1 and the volatile is loaded keeps both open until hardware reset, after which both read 0.
// - After a hardware reset with the nonvolatile freeze bit at 0, both registers are locked until the next power-on.
// - While unlocked, the host may change the volatile register whenever the device is idle and the change is taken.
// - With the burst-type bit set, the burst is linear and the word address counts up without end.
// - With burst type clear and length code 10, the burst wraps inside an aligned group of eight words.
// - With burst type clear and length code 11, the burst wraps inside an aligned group of sixteen words.
// - With burst type clear and length code 01, the burst wraps inside an aligned group of thirty-two words.
`ifndef CFGS_CFG_SVH
`define CFGS_CFG_SVH

// Register indices on the plain register port
`define CFGS_A_VOL 3'h0
`define CFGS_A_NONVOL 3'h1
`define CFGS_A_ERASE 3'h2
`define CFGS_A_STATUS 3'h3
`define CFGS_A_ACTIVE 3'h4
`define CFGS_A_SOFT 3'h5

// Configuration word values
`define CFGS_FACTORY 16'h8EBB
`define CFGS_ERASED 16'hFFFF

// Burst length codes
`define CFGS_BL_64 2'h1
`define CFGS_BL_16 2'h2
`define CFGS_BL_32 2'h3

// Wrap masks over the word address
`define CFGS_MASK_16 32'h0000_0007
`define CFGS_MASK_32 32'h0000_000F
`define CFGS_MASK_64 32'h0000_001F
`define CFGS_MASK_LIN 32'hFFFF_FFFF

`endif

// ---- hw/cfgs_pkg.sv ----
`include "cfgs_cfg.svh"

package cfgs_pkg;

    // Layout shared by both configuration registers
    typedef struct packed {
        logic rsvd_hi;
        logic [2:0] drive;
        logic freeze;
        logic ssr_freeze;
        logic [1:0] sector_map;
        logic [3:0] latency;
        logic rsvd_lo;
        logic rwds_stall;
        logic [1:0] burst_len;
    } cfgs_word_t;

    // Burst request decoded from the command-address word
    typedef struct packed {
        logic linear;
        logic [31:0] word_addr;
    } cfgs_cmd_t;

endpackage

// ---- hw/cfgs_top.sv ----
`timescale 1ns/1ns
`include "cfgs_cfg.svh"

module cfgs_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hw_reset_pin_n,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_q,
    output cfgs_pkg::cfgs_word_t active_cfg_q,
    input wire logic link_clk,
    input wire logic link_cmd_valid,
    input wire cfgs_pkg::cfgs_cmd_t link_cmd,
    input wire logic link_step,
    input wire logic link_end,
    output logic [31:0] link_word_addr_q,
    output logic link_busy_q
);
    import cfgs_pkg::*;

    // Wrap mask for a burst length code; reserved code runs linear
    function automatic logic [31:0] wrap_mask(input logic [1:0] bl);
        logic [31:0] m;
        m = `CFGS_MASK_LIN;
        if (bl == `CFGS_BL_16) begin
            m = `CFGS_MASK_16;
        end else if (bl == `CFGS_BL_32) begin
            m = `CFGS_MASK_32;
        end else if (bl == `CFGS_BL_64) begin
            m = `CFGS_MASK_64;
        end
        return m;
    endfunction

    // Next word: bits outside the mask held, bits inside count
    function automatic logic [31:0] next_word(input logic [31:0] a,
                                              input logic [31:0] m);
        logic [31:0] inc;
        inc = a + 32'h0000_0001;
        return (a & ~m) | (inc & m);
    endfunction

    logic hw_s1_q;
    logic hw_s2_q;
    logic cfg_rst;
    cfgs_word_t nv_q;
    cfgs_word_t vol_q;
    cfgs_word_t wcfg;
    logic src_vol_q;
    logic perm_q;
    logic refused_q;
    logic locked;
    logic wr_vol;
    logic wr_nv;
    logic wr_er;
    logic wr_soft;
    logic vol_ok;
    logic nv_ok;

    // Reset pin comes from outside, so two flops first
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hw_s1_q <= 1'b0;
            hw_s2_q <= 1'b0;
        end else begin
            hw_s1_q <= ~hw_reset_pin_n;
            hw_s2_q <= hw_s1_q;
        end
    end

    // Decode and write qualification
    assign cfg_rst = reset | hw_s2_q;
    assign wcfg = cfgs_word_t'(reg_wdata);
    assign locked = perm_q | ~vol_q.freeze;
    assign wr_vol = reg_wr && (reg_addr == `CFGS_A_VOL);
    assign wr_nv = reg_wr && (reg_addr == `CFGS_A_NONVOL);
    assign wr_er = reg_wr && (reg_addr == `CFGS_A_ERASE);
    assign wr_soft = reg_wr && (reg_addr == `CFGS_A_SOFT);
    assign vol_ok = wr_vol && !locked && !cfg_rst;
    assign nv_ok = (wr_nv || wr_er) && !locked && !cfg_rst;

    // Nonvolatile store; survives hardware reset, power-on restores it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            nv_q <= `CFGS_FACTORY;
        end else if (nv_ok && wr_er) begin
            nv_q <= `CFGS_ERASED;
        end else if (nv_ok) begin
            nv_q <= wcfg;
        end
    end

    // Permanent lock is decided only at a reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            perm_q <= 1'b0;
        end else if (hw_s2_q) begin
            perm_q <= ~nv_q.freeze;
        end
    end

    // Volatile register; mirrors nonvolatile after each reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            vol_q <= `CFGS_FACTORY;
        end else if (hw_s2_q) begin
            vol_q <= nv_q;
        end else if (vol_ok) begin
            vol_q <= wcfg;
        end else if (nv_ok && wr_nv && !src_vol_q) begin
            vol_q <= wcfg;
        end
    end

    // Source select; software reset has no path in here
    always_ff @(posedge sys_clk) begin
        if (cfg_rst) begin
            src_vol_q <= 1'b0;
        end else if (vol_ok) begin
            src_vol_q <= 1'b1;
        end
    end

    // Active settings; nonvolatile changes wait for a reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            active_cfg_q <= `CFGS_FACTORY;
        end else if (hw_s2_q) begin
            active_cfg_q <= nv_q;
        end else if (vol_ok) begin
            active_cfg_q <= wcfg;
        end
    end

    // Refused-write flag; a refusal beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            refused_q <= 1'b0;
        end else if ((wr_vol || wr_nv || wr_er) && locked) begin
            refused_q <= 1'b1;
        end else if (wr_soft) begin
            refused_q <= 1'b0;
        end
    end

    // Read data stand one cycle, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (reset || !reg_rd) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_addr == `CFGS_A_VOL) begin
            reg_rdata_q <= vol_q;
        end else if (reg_addr == `CFGS_A_NONVOL) begin
            reg_rdata_q <= nv_q;
        end else if (reg_addr == `CFGS_A_STATUS) begin
            reg_rdata_q <= {10'h000, active_cfg_q.burst_len, refused_q,
                            perm_q, locked, src_vol_q};
        end else if (reg_addr == `CFGS_A_ACTIVE) begin
            reg_rdata_q <= active_cfg_q;
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    // Link domain: reset and burst length brought across
    logic lrst_s1_q;
    logic link_rst_q;
    logic [1:0] bl_s1_q;
    logic [1:0] bl_s2_q;
    logic [1:0] bl_s3_q;
    logic [1:0] bl_q;
    logic [31:0] mask_q;
    logic lin_q;

    // Length is quasi-static: it only moves while the link is idle
    always_ff @(posedge link_clk) begin
        lrst_s1_q <= cfg_rst;
        link_rst_q <= lrst_s1_q;
        bl_s1_q <= active_cfg_q.burst_len;
        bl_s2_q <= bl_s1_q;
        bl_s3_q <= bl_s2_q;
    end

    // Length taken only when two samples agree, so a code caught
    // half-changed never reaches the mask
    always_ff @(posedge link_clk) begin
        if (bl_s2_q == bl_s3_q) begin
            bl_q <= bl_s3_q;
        end
    end

    // Burst address engine; length sampled once per burst
    always_ff @(posedge link_clk) begin
        if (link_rst_q) begin
            link_word_addr_q <= 32'h0000_0000;
            link_busy_q <= 1'b0;
            lin_q <= 1'b0;
            mask_q <= `CFGS_MASK_LIN;
        end else if (link_cmd_valid) begin
            link_word_addr_q <= link_cmd.word_addr;
            link_busy_q <= 1'b1;
            lin_q <= link_cmd.linear;
            mask_q <= link_cmd.linear ? `CFGS_MASK_LIN
                                      : wrap_mask(bl_q);
        end else if (link_end) begin
            link_busy_q <= 1'b0;
        end else if (link_step && link_busy_q) begin
            link_word_addr_q <= next_word(link_word_addr_q, mask_q);
        end
    end

    // Checks in the register domain
    property p_src_reset;
        @(posedge sys_clk) disable iff (reset)
        hw_s2_q |=> !src_vol_q && active_cfg_q == $past(nv_q);
    endproperty
    a_src_reset: assert property (p_src_reset)
        else $error("source not back to nonvolatile after reset");

    property p_soft_keep;
        @(posedge sys_clk) disable iff (reset)
        wr_soft && !cfg_rst |=> $stable(src_vol_q) && $stable(active_cfg_q);
    endproperty
    a_soft_keep: assert property (p_soft_keep)
        else $error("software reset moved the source");

    property p_nv_keeps_vol;
        @(posedge sys_clk) disable iff (reset)
        nv_ok && src_vol_q |=> $stable(vol_q);
    endproperty
    a_nv_keeps_vol: assert property (p_nv_keeps_vol)
        else $error("loaded volatile register changed by nv write");

    property p_nv_copy;
        @(posedge sys_clk) disable iff (reset)
        nv_ok && wr_nv && !src_vol_q |=> vol_q == $past(reg_wdata);
    endproperty
    a_nv_copy: assert property (p_nv_copy)
        else $error("unloaded volatile register missed nv copy");

    property p_nv_deferred;
        @(posedge sys_clk) disable iff (reset)
        nv_ok |=> $stable(active_cfg_q);
    endproperty
    a_nv_deferred: assert property (p_nv_deferred)
        else $error("nv write changed active settings");

    property p_vol_now;
        @(posedge sys_clk) disable iff (reset)
        vol_ok |=> active_cfg_q == $past(reg_wdata) && src_vol_q;
    endproperty
    a_vol_now: assert property (p_vol_now)
        else $error("volatile load not applied next cycle");

    property p_lock;
        @(posedge sys_clk) disable iff (reset)
        (wr_vol || wr_nv || wr_er) && locked && !cfg_rst
            |=> $stable(vol_q) && $stable(nv_q) && refused_q;
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked register changed");

    property p_freeze_temp;
        @(posedge sys_clk) disable iff (reset)
        nv_ok && wr_nv && src_vol_q && nv_q.freeze && !wcfg.freeze
            |=> !locked && !nv_q.freeze;
    endproperty
    a_freeze_temp: assert property (p_freeze_temp)
        else $error("registers locked before reset");

    property p_perm;
        @(posedge sys_clk) disable iff (reset)
        hw_s2_q && !nv_q.freeze |=> perm_q && locked && !vol_q.freeze;
    endproperty
    a_perm: assert property (p_perm)
        else $error("permanent lock missing after reset");

    property p_idle_load;
        @(posedge sys_clk) disable iff (reset)
        wr_vol && !locked && !cfg_rst |=> vol_q == $past(reg_wdata);
    endproperty
    a_idle_load: assert property (p_idle_load)
        else $error("unlocked volatile write not taken");

    // Checks in the link domain
    sequence s_step;
        link_step && link_busy_q && !link_cmd_valid && !link_end;
    endsequence

    property p_linear;
        @(posedge link_clk) disable iff (link_rst_q)
        s_step and lin_q |=> link_word_addr_q == $past(link_word_addr_q)
                                               + 32'h0000_0001;
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear burst did not increment");

    property p_wrap16;
        @(posedge link_clk) disable iff (link_rst_q)
        s_step and mask_q == `CFGS_MASK_16
            |=> link_word_addr_q[2:0] == $past(link_word_addr_q[2:0]) + 3'h1;
    endproperty
    a_wrap16: assert property (p_wrap16)
        else $error("16-byte wrap order wrong");

    property p_wrap32;
        @(posedge link_clk) disable iff (link_rst_q)
        s_step and mask_q == `CFGS_MASK_32
            |=> link_word_addr_q[3:0] == $past(link_word_addr_q[3:0]) + 4'h1;
    endproperty
    a_wrap32: assert property (p_wrap32)
        else $error("32-byte wrap order wrong");

    property p_wrap64;
        @(posedge link_clk) disable iff (link_rst_q)
        s_step and mask_q == `CFGS_MASK_64
            |=> link_word_addr_q[4:0] == $past(link_word_addr_q[4:0]) + 5'h01;
    endproperty
    a_wrap64: assert property (p_wrap64)
        else $error("64-byte wrap order wrong");

    property p_upper_fixed;
        @(posedge link_clk) disable iff (link_rst_q)
        s_step and !lin_q |=> (link_word_addr_q & ~mask_q)
                              == $past(link_word_addr_q & ~mask_q);
    endproperty
    a_upper_fixed: assert property (p_upper_fixed)
        else $error("wrap moved bits above the group");

endmodule

// ---- testbench/cfgs_link_host.sv ----
`timescale 1ns/1ns

module cfgs_link_host (
    input wire logic link_clk,
    input wire logic [31:0] link_word_addr_q,
    input wire logic link_busy_q,
    output logic link_cmd_valid,
    output cfgs_pkg::cfgs_cmd_t link_cmd,
    output logic link_step,
    output logic link_end
);
    import cfgs_pkg::*;

    logic [31:0] got [$];
    logic busy_mid;
    logic busy_seen;

    // Idle bus at time zero
    initial begin
        link_cmd_valid = 1'h0;
        link_cmd = '0;
        link_step = 1'h0;
        link_end = 1'h0;
    end

    // One burst; slow mode stalls a cycle after every word
    task automatic run(input logic l, input logic [31:0] s, input int n,
                       input logic slow);
        int i;
        got.delete();
        // Lets the burst length settle across domains
        repeat (5) @(posedge link_clk);
        link_cmd_valid <= 1'h1;
        link_cmd <= {l, s};
        @(posedge link_clk);
        link_cmd_valid <= 1'h0;
        link_cmd <= ~{l, s}; // Released bus never shows the old command
        for (i = 0; i < n; i++) begin
            link_step <= 1'h1;
            @(negedge link_clk);
            got.push_back(link_word_addr_q);
            if (i == 0)
                busy_mid = link_busy_q;
            @(posedge link_clk);
            if (slow) begin
                link_step <= 1'h0;
                @(posedge link_clk);
            end
        end
        // Burst closed so the device is idle again
        link_step <= 1'h0;
        link_end <= 1'h1;
        @(posedge link_clk);
        link_end <= 1'h0;
        @(negedge link_clk);
        busy_seen = link_busy_q;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`include "cfgs_cfg.svh"

module tb_top;
    import cfgs_pkg::*;

    logic sys_clk, reset, hw_reset_pin_n, link_clk;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q;
    logic reg_wr, reg_rd, link_cmd_valid, link_step, link_end, link_busy_q;
    cfgs_word_t active_cfg_q;
    cfgs_cmd_t link_cmd;
    logic [31:0] link_word_addr_q;
    int err_count, total_checks;

    cfgs_top dut (
        .sys_clk(sys_clk), .reset(reset), .hw_reset_pin_n(hw_reset_pin_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .active_cfg_q(active_cfg_q), .link_clk(link_clk),
        .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd),
        .link_step(link_step), .link_end(link_end),
        .link_word_addr_q(link_word_addr_q), .link_busy_q(link_busy_q)
    );

    cfgs_link_host host (
        .link_clk(link_clk), .link_word_addr_q(link_word_addr_q),
        .link_busy_q(link_busy_q), .link_cmd_valid(link_cmd_valid),
        .link_cmd(link_cmd), .link_step(link_step), .link_end(link_end)
    );

    // Edges of the two clocks coincide only once every 80 ns
    always #5 sys_clk = ~sys_clk;
    always #16 link_clk = ~link_clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rd(input logic [2:0] a, input logic [15:0] e,
            input logic [15:0] m = 16'hFFFF);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        check({16'h0, reg_rdata_q & m}, {16'h0, e});
    endtask

    task hwr;
        @(posedge sys_clk);
        hw_reset_pin_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        hw_reset_pin_n <= 1'h1;
        repeat (5) @(posedge sys_clk);
    endtask

    task burst(input logic l, input logic [31:0] s, input logic [31:0] m,
               input int n, input logic slow);
        int i;
        host.run(l, s, n, slow);
        check({31'h0, host.busy_mid}, 32'h1);
        check({31'h0, host.busy_seen}, 32'h0);
        for (i = 0; i < n; i++) begin
            check(host.got[i], l ? s + i : (s & ~m) | ((s + i) & m));
        end
    endtask

    task t_reset;
        check({16'h0, active_cfg_q}, {16'h0, `CFGS_FACTORY});
        rd(`CFGS_A_VOL, `CFGS_FACTORY);
        rd(`CFGS_A_STATUS, 16'h0030, 16'h003F);
        rd(3'h6, 16'h0000);
    endtask

    task t_volatile;
        wr(`CFGS_A_NONVOL, 16'h8EBA);
        rd(`CFGS_A_VOL, 16'h8EBA);
        rd(`CFGS_A_ACTIVE, `CFGS_FACTORY);
        wr(`CFGS_A_VOL, 16'h8EB9);
        rd(`CFGS_A_ACTIVE, 16'h8EB9);
        rd(`CFGS_A_STATUS, 16'h0011, 16'h003F);
    endtask

    task t_isolate;
        wr(`CFGS_A_NONVOL, 16'h8EBB);
        wr(`CFGS_A_ERASE, 16'h0000);
        rd(`CFGS_A_NONVOL, `CFGS_ERASED);
        rd(`CFGS_A_VOL, 16'h8EB9);
        wr(`CFGS_A_SOFT, 16'h0000);
        rd(`CFGS_A_STATUS, 16'h0011, 16'h003F);
        hwr();
        rd(`CFGS_A_ACTIVE, `CFGS_ERASED);
        rd(`CFGS_A_STATUS, 16'h0030, 16'h003F);
    endtask

    task t_bursts;
        wr(`CFGS_A_VOL, 16'hFFFE);
        burst(1'h1, 32'h0000_FFFE, 32'h0, 24, 1'h0);
        burst(1'h0, 32'h0000_0002, `CFGS_MASK_16, 8, 1'h0);
        burst(1'h0, 32'h5A5A_A50C, `CFGS_MASK_16, 10, 1'h1);
        wr(`CFGS_A_VOL, 16'hFFFF);
        burst(1'h0, 32'h0000_000A, `CFGS_MASK_32, 16, 1'h0);
        burst(1'h0, 32'h0000_001E, `CFGS_MASK_32, 18, 1'h0);
        wr(`CFGS_A_VOL, 16'hFFFD);
        burst(1'h0, 32'h0000_0003, `CFGS_MASK_64, 32, 1'h0);
        burst(1'h0, 32'h1234_562E, `CFGS_MASK_64, 34, 1'h1);
    endtask

    task t_lock;
        wr(`CFGS_A_VOL, 16'hF7FE);
        rd(`CFGS_A_ACTIVE, 16'hF7FE);
        wr(`CFGS_A_VOL, 16'hFFFE);
        wr(`CFGS_A_NONVOL, 16'h1234);
        rd(`CFGS_A_VOL, 16'hF7FE);
        rd(`CFGS_A_NONVOL, `CFGS_ERASED);
        rd(`CFGS_A_STATUS, 16'h002B, 16'h003F);
        wr(`CFGS_A_SOFT, 16'h0000);
        rd(`CFGS_A_STATUS, 16'h0023, 16'h003F);
        hwr();
        rd(`CFGS_A_STATUS, 16'h0030, 16'h003F);
    endtask

    task t_freeze;
        wr(`CFGS_A_VOL, `CFGS_ERASED);
        wr(`CFGS_A_NONVOL, 16'hF7FF);
        rd(`CFGS_A_VOL, `CFGS_ERASED);
        wr(`CFGS_A_VOL, 16'hFFFE);
        rd(`CFGS_A_VOL, 16'hFFFE);
        rd(`CFGS_A_STATUS, 16'h0021, 16'h003F);
        hwr();
        rd(`CFGS_A_VOL, 16'hF7FF);
        rd(`CFGS_A_STATUS, 16'h0036, 16'h003F);
        wr(`CFGS_A_VOL, `CFGS_ERASED);
        wr(`CFGS_A_NONVOL, `CFGS_ERASED);
        rd(`CFGS_A_VOL, 16'hF7FF);
        rd(`CFGS_A_NONVOL, 16'hF7FF);
    endtask

    // Main sequence; the permanent lock comes last as it cannot be undone
    initial begin
        sys_clk = 1'h0;
        link_clk = 1'h0;
        reset = 1'h1;
        hw_reset_pin_n = 1'h1;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'h0;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_volatile();
        t_isolate();
        t_bursts();
        t_lock();
        t_freeze();
        test_done();
    end

    // Whole run needs well under a tenth of this
    initial begin
        #300000;
        err_count++;
        test_done();
    end
endmodule
